// *** sink_video_pkg.sv ***
package sink_video_pkg;

	// Pixel and beat geometry
	localparam int          PIX_PER_BEAT   = 4;
	localparam int          COMP_W         = 16;
	localparam int          PIX_W          = 48;
	localparam int          BEAT_W         = 192;
	localparam int          NUM_STREAMS    = 4;
	localparam int          BUF_DEPTH      = 2;

	// Native pixel field positions (MSB-aligned components)
	localparam int          NAT_HI_LSB     = 32;
	localparam int          NAT_MID_LSB    = 16;
	localparam int          NAT_LO_LSB     = 0;

	// Stream slot positions inside a pixel
	localparam int          SLOT1_LSB      = 0;
	localparam int          SLOT2_LSB      = 16;
	localparam int          SLOT3_LSB      = 32;

	// Colour formats
	localparam logic [1:0]  FMT_RGB        = 2'h0;
	localparam logic [1:0]  FMT_YCC444     = 2'h1;
	localparam logic [1:0]  FMT_YCC422     = 2'h2;
	localparam logic [1:0]  FMT_YONLY      = 2'h3;

	// Bits per component codes
	localparam logic [2:0]  BPC_6          = 3'h0;
	localparam logic [2:0]  BPC_8          = 3'h1;
	localparam logic [2:0]  BPC_10         = 3'h2;
	localparam logic [2:0]  BPC_12         = 3'h3;
	localparam logic [2:0]  BPC_16         = 3'h4;
	localparam logic [15:0] MASK_6         = 16'hfc00;
	localparam logic [15:0] MASK_8         = 16'hff00;
	localparam logic [15:0] MASK_10        = 16'hffc0;
	localparam logic [15:0] MASK_12        = 16'hfff0;
	localparam logic [15:0] MASK_16        = 16'hffff;

	// Pixels per beat codes
	localparam logic [1:0]  PPC_1          = 2'h0;
	localparam logic [1:0]  PPC_2          = 2'h1;
	localparam logic [1:0]  PPC_4          = 2'h2;

	// Lane rates and link clock
	localparam logic [1:0]  RATE_1G62      = 2'h0;
	localparam logic [1:0]  RATE_2G7       = 2'h1;
	localparam logic [1:0]  RATE_5G4       = 2'h2;
	localparam logic [1:0]  RATE_8G1       = 2'h3;
	localparam logic [13:0] RATE_1G62_MBPS = 14'h0654;
	localparam logic [13:0] RATE_2G7_MBPS  = 14'h0a8c;
	localparam logic [13:0] RATE_5G4_MBPS  = 14'h1518;
	localparam logic [13:0] RATE_8G1_MBPS  = 14'h1fa4;
	localparam logic [13:0] PHY_WORD_DIV   = 14'h0014;
	localparam int          PHY_DATA_W     = 16;

	// Host clock and auxiliary timing
	localparam int          CLOCK_MHZ      = 25;
	localparam int          HOST_MAX_MHZ   = 135;
	localparam int          AUX_TICK_NS    = 1000;
	localparam int          AUX_TICK_CYC   = (AUX_TICK_NS * CLOCK_MHZ + 999) / 1000;
	localparam logic [7:0]  AUX_TICK_LAST  = 8'(AUX_TICK_CYC - 1);

	// Clock-recovery attribute widths
	localparam int          MN_W           = 24;

	// Sub-block address map
	localparam logic [31:0] SUBSYS_BASE    = 32'h44c0_0000;
	localparam int          SUBSYS_SPAN_W  = 14;
	localparam int          SUB_STEP_LSB   = 12;
	localparam logic [1:0]  SUB_RX_CORE    = 2'h0;
	localparam logic [1:0]  SUB_I2C        = 2'h1;
	localparam logic [1:0]  SUB_PROTECT    = 2'h2;
	localparam logic [1:0]  SUB_TIMER      = 2'h3;

	// General-purpose output bit driving the retimer reset
	localparam int          RETIMER_GPO_BIT = 0;
	localparam int          GPO_W           = 8;

endpackage

// *** pixel_beat_buffer.sv ***
`timescale 1ns/1ps
`default_nettype none
module pixel_beat_buffer #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 2
) (
	input  wire logic             i_clock,
	input  wire logic             i_rst_b,
	input  wire logic             i_flush,
	input  wire logic [WIDTH-1:0] i_in_data,
	input  wire logic             i_in_valid,
	output logic                  o_in_ready,
	output logic      [WIDTH-1:0] o_out_data,
	output logic                  o_out_valid,
	input  wire logic             i_out_ready
);
	localparam int PTR_W = (DEPTH > 1) ? $clog2(DEPTH) : 1;
	localparam int CNT_W = $clog2(DEPTH + 1);
	localparam logic [CNT_W-1:0] CNT_FULL = CNT_W'(DEPTH);
	localparam logic [PTR_W-1:0] PTR_LAST = PTR_W'(DEPTH - 1);

	logic [WIDTH-1:0] mem_reg [DEPTH];
	logic [PTR_W-1:0] wr_ptr_reg;
	logic [PTR_W-1:0] rd_ptr_reg;
	logic [CNT_W-1:0] count_reg;
	logic             push;
	logic             pop;

	assign o_in_ready  = (count_reg != CNT_FULL);
	assign o_out_valid = (count_reg != '0);
	assign o_out_data  = mem_reg[rd_ptr_reg];
	assign push        = i_in_valid && o_in_ready;
	assign pop         = o_out_valid && i_out_ready;

	// Storage words
	always_ff @(posedge i_clock) begin
		if (push) begin
			mem_reg[wr_ptr_reg] <= i_in_data;
		end
	end

	// Pointers and fill level
	always_ff @(posedge i_clock) begin
		if (!i_rst_b || i_flush) begin
			wr_ptr_reg <= '0;
			rd_ptr_reg <= '0;
			count_reg  <= '0;
		end else begin
			if (push) begin
				wr_ptr_reg <= (wr_ptr_reg == PTR_LAST) ? '0 : wr_ptr_reg + 1'b1;
			end
			if (pop) begin
				rd_ptr_reg <= (rd_ptr_reg == PTR_LAST) ? '0 : rd_ptr_reg + 1'b1;
			end
			if (push && !pop) begin
				count_reg <= count_reg + 1'b1;
			end else if (pop && !push) begin
				count_reg <= count_reg - 1'b1;
			end
		end
	end
endmodule
`default_nettype wire

// *** sink_video_stream_output_map.sv ***
// Overview of operation
// - Slots: green/luma, blue/chroma, red; pixel0 lowest
// - 4:2:2 alternates Cr/Cb; slot3 unused
// - Link clock follows lane rate table
// - Link clock equals lane rate over twenty
// - Receive logic runs in link clock domain; here it runs on i_clock, the host clock
// - Present clock ratio values, pulse on change
// - Aux timing from host clock, max 135MHz
// - Host reset returns all registers but the buffer storage words to reset
// - One active-high pipe reset per stream
// - Retimer reset driven from I2C general output
// - Bridge has no software-visible registers
// - Sub-blocks at 4KB steps from base
// - Components MSB-first, unused low bits zero
`timescale 1ns/1ps
`default_nettype none
module sink_video_stream_output_map (
	input  wire logic                                   i_clock,
	input  wire logic                                   i_rst_b,
	input  wire logic [sink_video_pkg::NUM_STREAMS-1:0] i_vid_rst,
	input  wire logic [sink_video_pkg::BEAT_W-1:0]      i_pix_data,
	input  wire logic                                   i_pix_valid,
	output logic                                        o_pix_ready,
	input  wire logic                                   i_pix_sof,
	input  wire logic                                   i_pix_eol,
	input  wire logic [1:0]                             i_format,
	input  wire logic [2:0]                             i_bpc,
	input  wire logic [1:0]                             i_ppc,
	output logic      [sink_video_pkg::BEAT_W-1:0]      o_axis_tdata,
	output logic                                        o_axis_tvalid,
	input  wire logic                                   i_axis_tready,
	output logic                                        o_axis_tuser,
	output logic                                        o_axis_tlast,
	output logic      [sink_video_pkg::PIX_PER_BEAT-1:0] o_axis_chroma_cb,
	input  wire logic [sink_video_pkg::MN_W-1:0]        i_msa_m,
	input  wire logic [sink_video_pkg::MN_W-1:0]        i_msa_n,
	input  wire logic                                   i_msa_valid,
	output logic      [sink_video_pkg::MN_W-1:0]        o_vid_m,
	output logic      [sink_video_pkg::MN_W-1:0]        o_vid_n,
	output logic                                        o_mn_update,
	input  wire logic [1:0]                             i_lane_rate,
	output logic      [13:0]                            o_link_clk_mhz,
	output logic                                        o_aux_tick,
	input  wire logic [sink_video_pkg::GPO_W-1:0]       i_i2c_gpo,
	output logic                                        o_retimer_soft_reset,
	output logic      [sink_video_pkg::NUM_STREAMS-1:0] o_vid_pipe_rst,
	input  wire logic [31:0]                            i_host_addr,
	output logic      [3:0]                             o_sub_sel,
	output logic                                        o_addr_hit
);
	localparam int BUF_W = sink_video_pkg::BEAT_W + sink_video_pkg::PIX_PER_BEAT + 2;

	function automatic logic [15:0] comp_mask(input logic [2:0] bpc);
		logic [15:0] m;
		m = sink_video_pkg::MASK_8;
		unique case (bpc)
			sink_video_pkg::BPC_6:  m = sink_video_pkg::MASK_6;
			sink_video_pkg::BPC_8:  m = sink_video_pkg::MASK_8;
			sink_video_pkg::BPC_10: m = sink_video_pkg::MASK_10;
			sink_video_pkg::BPC_12: m = sink_video_pkg::MASK_12;
			sink_video_pkg::BPC_16: m = sink_video_pkg::MASK_16;
			default:                m = sink_video_pkg::MASK_8;
		endcase
		return m;
	endfunction

	function automatic logic [2:0] pix_count(input logic [1:0] ppc);
		logic [2:0] n;
		n = 3'h4;
		unique case (ppc)
			sink_video_pkg::PPC_1: n = 3'h1;
			sink_video_pkg::PPC_2: n = 3'h2;
			sink_video_pkg::PPC_4: n = 3'h4;
			default:               n = 3'h4;
		endcase
		return n;
	endfunction

	function automatic logic [3:0] sub_decode(input logic [31:0] addr);
		logic [3:0] sel;
		sel = 4'h0;
		if (addr[31:sink_video_pkg::SUBSYS_SPAN_W] ==
		    sink_video_pkg::SUBSYS_BASE[31:sink_video_pkg::SUBSYS_SPAN_W]) begin
			sel[addr[sink_video_pkg::SUBSYS_SPAN_W-1:sink_video_pkg::SUB_STEP_LSB]] = 1'b1;
		end
		return sel;
	endfunction

	function automatic logic [13:0] rate_mbps(input logic [1:0] rate);
		logic [13:0] r;
		r = sink_video_pkg::RATE_1G62_MBPS;
		unique case (rate)
			sink_video_pkg::RATE_1G62: r = sink_video_pkg::RATE_1G62_MBPS;
			sink_video_pkg::RATE_2G7:  r = sink_video_pkg::RATE_2G7_MBPS;
			sink_video_pkg::RATE_5G4:  r = sink_video_pkg::RATE_5G4_MBPS;
			sink_video_pkg::RATE_8G1:  r = sink_video_pkg::RATE_8G1_MBPS;
		endcase
		return r;
	endfunction

	logic                                       pipe_rst;
	logic [15:0]                                mask;
	logic [2:0]                                 npix;
	logic [sink_video_pkg::BEAT_W-1:0]          mapped;
	logic [sink_video_pkg::PIX_PER_BEAT-1:0]    cb_flags;
	logic                                       phase_reg;
	logic [BUF_W-1:0]                           buf_in;
	logic [BUF_W-1:0]                           buf_out;
	logic                                       buf_in_ready;
	logic                                       accept;
	logic [sink_video_pkg::MN_W-1:0]            vid_m_reg;
	logic [sink_video_pkg::MN_W-1:0]            vid_n_reg;
	logic                                       mn_update_reg;
	logic [13:0]                                link_clk_reg;
	logic [7:0]                                 aux_cnt_reg;
	logic                                       aux_tick_reg;
	logic                                       retimer_rst_reg;
	logic [sink_video_pkg::NUM_STREAMS-1:0]     pipe_rst_reg;
	logic [3:0]                                 sub_sel_reg;
	logic                                       addr_hit_reg;

	// The whole pipe runs on i_clock, the host clock that also times the aux tick
	assign pipe_rst    = i_vid_rst[0];
	assign mask        = comp_mask(i_bpc);
	assign npix        = pix_count(i_ppc);
	assign o_pix_ready = buf_in_ready;
	assign accept      = i_pix_valid && buf_in_ready;

	// Per-pixel component placement
	genvar k;
	generate
		for (k = 0; k < sink_video_pkg::PIX_PER_BEAT; k++) begin : g_pix
			logic [15:0] hi;
			logic [15:0] mid;
			logic [15:0] lo;
			logic [15:0] slot1;
			logic [15:0] slot2;
			logic [15:0] slot3;
			logic        used;
			assign hi   = i_pix_data[k*sink_video_pkg::PIX_W+sink_video_pkg::NAT_HI_LSB +: 16];
			assign mid  = i_pix_data[k*sink_video_pkg::PIX_W+sink_video_pkg::NAT_MID_LSB +: 16];
			assign lo   = i_pix_data[k*sink_video_pkg::PIX_W+sink_video_pkg::NAT_LO_LSB +: 16];
			assign used = (3'(k) < npix);
			always_comb begin
				slot1 = 16'h0000;
				slot2 = 16'h0000;
				slot3 = 16'h0000;
				if (used) begin
					unique case (i_format)
						sink_video_pkg::FMT_RGB, sink_video_pkg::FMT_YCC444: begin
							slot1 = mid & mask;
							slot2 = lo & mask;
							slot3 = hi & mask;
						end
						sink_video_pkg::FMT_YCC422: begin
							slot1 = mid & mask;
							slot2 = hi & mask;
						end
						sink_video_pkg::FMT_YONLY: begin
							slot1 = hi & mask;
						end
					endcase
				end
			end
			// Pixel 0 sits in the lowest bits of the beat
			assign mapped[k*sink_video_pkg::PIX_W+sink_video_pkg::SLOT1_LSB +: 16] = slot1;
			assign mapped[k*sink_video_pkg::PIX_W+sink_video_pkg::SLOT2_LSB +: 16] = slot2;
			assign mapped[k*sink_video_pkg::PIX_W+sink_video_pkg::SLOT3_LSB +: 16] = slot3;
			// Chroma kind alternates pixel by pixel
			assign cb_flags[k] = (i_format == sink_video_pkg::FMT_YCC422) && used &&
			                     (phase_reg ^ 1'(k));
		end
	endgenerate

	// Chroma phase carried across beats, restarted each line
	always_ff @(posedge i_clock) begin
		if (!i_rst_b || pipe_rst) begin
			phase_reg <= 1'b0;
		end else if (accept) begin
			if (i_pix_eol || i_pix_sof) begin
				phase_reg <= i_pix_sof && !i_pix_eol && npix[0];
			end else begin
				phase_reg <= phase_reg ^ npix[0];
			end
		end
	end

	assign buf_in = {i_pix_sof, i_pix_eol, cb_flags, mapped};

	// Two-entry buffer absorbs receiver stalls
	pixel_beat_buffer #(
		.WIDTH (BUF_W),
		.DEPTH (sink_video_pkg::BUF_DEPTH)
	) u_beat_buffer (
		.i_clock     (i_clock),
		.i_rst_b     (i_rst_b),
		.i_flush     (pipe_rst),
		.i_in_data   (buf_in),
		.i_in_valid  (i_pix_valid),
		.o_in_ready  (buf_in_ready),
		.o_out_data  (buf_out),
		.o_out_valid (o_axis_tvalid),
		.i_out_ready (i_axis_tready)
	);

	assign o_axis_tdata     = buf_out[sink_video_pkg::BEAT_W-1:0];
	assign o_axis_chroma_cb = buf_out[sink_video_pkg::BEAT_W +: sink_video_pkg::PIX_PER_BEAT];
	assign o_axis_tlast     = buf_out[BUF_W-2];
	assign o_axis_tuser     = buf_out[BUF_W-1];

	// Clock-ratio values and change flag
	always_ff @(posedge i_clock) begin
		if (!i_rst_b) begin
			vid_m_reg     <= '0;
			vid_n_reg     <= '0;
			mn_update_reg <= 1'b0;
		end else begin
			mn_update_reg <= 1'b0;
			if (i_msa_valid && ((i_msa_m != vid_m_reg) || (i_msa_n != vid_n_reg))) begin
				vid_m_reg     <= i_msa_m;
				vid_n_reg     <= i_msa_n;
				mn_update_reg <= 1'b1;
			end
		end
	end

	assign o_vid_m     = vid_m_reg;
	assign o_vid_n     = vid_n_reg;
	assign o_mn_update = mn_update_reg;

	// Expected link clock for the selected lane rate
	always_ff @(posedge i_clock) begin
		if (!i_rst_b) begin
			link_clk_reg <= '0;
		end else begin
			link_clk_reg <= rate_mbps(i_lane_rate) / sink_video_pkg::PHY_WORD_DIV;
		end
	end

	assign o_link_clk_mhz = link_clk_reg;

	// Auxiliary timing tick from the host clock
	always_ff @(posedge i_clock) begin
		if (!i_rst_b) begin
			aux_cnt_reg  <= '0;
			aux_tick_reg <= 1'b0;
		end else if (aux_cnt_reg == sink_video_pkg::AUX_TICK_LAST) begin
			aux_cnt_reg  <= '0;
			aux_tick_reg <= 1'b1;
		end else begin
			aux_cnt_reg  <= aux_cnt_reg + 8'h01;
			aux_tick_reg <= 1'b0;
		end
	end

	assign o_aux_tick = aux_tick_reg;

	// Retimer reset follows the I2C general-purpose output
	always_ff @(posedge i_clock) begin
		if (!i_rst_b) begin
			retimer_rst_reg <= 1'b0;
		end else begin
			retimer_rst_reg <= i_i2c_gpo[sink_video_pkg::RETIMER_GPO_BIT];
		end
	end

	assign o_retimer_soft_reset = retimer_rst_reg;

	// Independent active-high pipe reset for each stream
	genvar s;
	generate
		for (s = 0; s < sink_video_pkg::NUM_STREAMS; s++) begin : g_stream_rst
			always_ff @(posedge i_clock) begin
				if (!i_rst_b) begin
					pipe_rst_reg[s] <= 1'b1;
				end else begin
					pipe_rst_reg[s] <= i_vid_rst[s];
				end
			end
		end
	endgenerate

	assign o_vid_pipe_rst = pipe_rst_reg;

	// Sub-block select; the bridge itself claims no address
	always_ff @(posedge i_clock) begin
		if (!i_rst_b) begin
			sub_sel_reg  <= 4'h0;
			addr_hit_reg <= 1'b0;
		end else begin
			sub_sel_reg  <= sub_decode(i_host_addr);
			addr_hit_reg <= |sub_decode(i_host_addr);
		end
	end

	assign o_sub_sel  = sub_sel_reg;
	assign o_addr_hit = addr_hit_reg;
endmodule
`default_nettype wire

// *** sink_axis_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module sink_axis_model (
	input  wire logic       i_clock,
	input  wire logic [1:0] i_stall,
	output logic            o_ready
);
	int seed = 59516;
	// Sink runs on the pipe clock, so never slower than the video side
	// Ready moves only off the sampling edge: 0 always, 1 random, else stalled
	always @(negedge i_clock) begin
		case (i_stall)
			2'h0: o_ready <= 1'b1;
			2'h1: o_ready <= ($random(seed) % 4) != 0;
			default: o_ready <= 1'b0;
		endcase
	end
endmodule
`default_nettype wire

// *** sink_video_stream_output_map_properties.sv ***
`timescale 1ns/1ps
`default_nettype none
module sink_video_stream_output_map_properties (
	input wire logic                                   i_clock,
	input wire logic                                   i_rst_b,
	input wire logic [sink_video_pkg::NUM_STREAMS-1:0] i_vid_rst,
	input wire logic                                   i_pix_valid,
	input wire logic                                   o_pix_ready,
	input wire logic                                   i_pix_sof,
	input wire logic                                   i_pix_eol,
	input wire logic [1:0]                             i_format,
	input wire logic [sink_video_pkg::BEAT_W-1:0]      o_axis_tdata,
	input wire logic                                   o_axis_tvalid,
	input wire logic                                   i_axis_tready,
	input wire logic                                   o_axis_tuser,
	input wire logic                                   o_axis_tlast,
	input wire logic [sink_video_pkg::MN_W-1:0]        i_msa_m,
	input wire logic [sink_video_pkg::MN_W-1:0]        i_msa_n,
	input wire logic                                   i_msa_valid,
	input wire logic [sink_video_pkg::MN_W-1:0]        o_vid_m,
	input wire logic [sink_video_pkg::MN_W-1:0]        o_vid_n,
	input wire logic                                   o_mn_update,
	input wire logic [1:0]                             i_lane_rate,
	input wire logic [13:0]                            o_link_clk_mhz,
	input wire logic                                   o_aux_tick,
	input wire logic [sink_video_pkg::GPO_W-1:0]       i_i2c_gpo,
	input wire logic                                   o_retimer_soft_reset,
	input wire logic [sink_video_pkg::NUM_STREAMS-1:0] o_vid_pipe_rst,
	input wire logic [31:0]                            i_host_addr,
	input wire logic [3:0]                             o_sub_sel,
	input wire logic                                   o_addr_hit
);
	logic [13:0] lnk [4] = '{14'h51, 14'h87, 14'h10e, 14'h195};
	wire         take = i_pix_valid && o_pix_ready && !o_axis_tvalid && !i_vid_rst[0];
	wire         mn_chg = i_msa_valid && (i_msa_m != o_vid_m || i_msa_n != o_vid_n);
	default clocking @(posedge i_clock);
	endclocking
	default disable iff (!i_rst_b);
	chk_out_hold: assert property (
		o_axis_tvalid && !i_axis_tready && !i_vid_rst[0] |=> o_axis_tvalid && $stable(o_axis_tdata))
		else $error("Stalled beat changed");
	chk_full_refuse: assert property (!o_pix_ready |-> o_axis_tvalid)
		else $error("Refused while empty");
	chk_beat_flags: assert property (
		take |=> o_axis_tvalid && o_axis_tuser == $past(i_pix_sof) && o_axis_tlast == $past(i_pix_eol))
		else $error("Beat not presented next cycle");
	chk_slot3_zero: assert property (
		take && i_format == sink_video_pkg::FMT_YCC422
		|=> o_axis_tdata[47:32] == 16'h0 && o_axis_tdata[191:176] == 16'h0)
		else $error("Third slot used in 4:2:2");
	chk_mn_pulse: assert property (
		mn_chg |=> o_mn_update && o_vid_m == $past(i_msa_m) && o_vid_n == $past(i_msa_n))
		else $error("Ratio change not flagged");
	chk_mn_quiet: assert property (!mn_chg |=> !o_mn_update)
		else $error("Spurious ratio update");
	chk_link_rate: assert property (1'b1 |=> o_link_clk_mhz == lnk[$past(i_lane_rate)])
		else $error("Link clock value wrong");
	chk_retimer_copy: assert property (
		1'b1 |=> o_retimer_soft_reset == $past(i_i2c_gpo[0]))
		else $error("Retimer reset wrong");
	chk_pipe_rst: assert property (1'b1 |=> o_vid_pipe_rst == $past(i_vid_rst))
		else $error("Pipe reset wrong");
	chk_addr_map: assert property (
		1'b1 |=> o_addr_hit == (o_sub_sel != 4'h0) && o_sub_sel == ($past(i_host_addr[31:14])
		== 18'h11300 ? 4'h1 << $past(i_host_addr[13:12]) : 4'h0))
		else $error("Address decode wrong");
	chk_aux_period: assert property (
		o_aux_tick |=> !o_aux_tick [*8] ##16 !o_aux_tick ##1 o_aux_tick)
		else $error("Aux tick period wrong");
endmodule
bind sink_video_stream_output_map sink_video_stream_output_map_properties i_chk (.*);
`default_nettype wire

// *** tb_sink_video_stream_output_map.sv ***
`timescale 1ns/1ps
`default_nettype none
module tb_sink_video_stream_output_map;
	typedef struct packed {logic [191:0] d; logic u; logic l; logic [3:0] cb; logic [3:0] m;} exp_t;
	logic         i_clock = 1'b0;
	logic         i_rst_b = 1'b0;
	logic [3:0]   i_vid_rst = 4'h0;
	logic [191:0] i_pix_data = '0;
	logic         i_pix_valid = 1'b0;
	logic         i_pix_sof = 1'b0;
	logic         i_pix_eol = 1'b0;
	logic [1:0]   i_format = 2'h0;
	logic [2:0]   i_bpc = 3'h0;
	logic [1:0]   i_ppc = 2'h0;
	logic         i_axis_tready;
	logic [23:0]  i_msa_m = 24'h0;
	logic [23:0]  i_msa_n = 24'h0;
	logic         i_msa_valid = 1'b0;
	logic [1:0]   i_lane_rate = 2'h0;
	logic [7:0]   i_i2c_gpo = 8'h0;
	logic [31:0]  i_host_addr = 32'h0;
	logic         o_pix_ready, o_axis_tvalid, o_axis_tuser, o_axis_tlast, o_mn_update;
	logic         o_aux_tick, o_retimer_soft_reset, o_addr_hit;
	logic [191:0] o_axis_tdata;
	logic [3:0]   o_axis_chroma_cb, o_vid_pipe_rst, o_sub_sel;
	logic [23:0]  o_vid_m, o_vid_n;
	logic [13:0]  o_link_clk_mhz;
	logic [1:0]   stall = 2'h1;
	logic [13:0]  lnk [4] = '{14'h51, 14'h87, 14'h10e, 14'h195};
	int           seed = 59516;
	int           failures = 0;
	int           cmp_count = 0;
	int           pix_cnt = 0;
	int           n;
	exp_t         q [$];
	exp_t         mon_x;
	always #20 i_clock = ~i_clock;
	sink_video_stream_output_map i_sink_video_stream_output_map (.*);
	sink_axis_model i_sink_axis_model (.i_clock(i_clock), .i_stall(stall), .o_ready(i_axis_tready));
	task automatic chk(input logic [191:0] s, input logic [191:0] e);
		cmp_count++;
		if (s !== e) begin
			failures++;
			$display("Error at %0t: seen %h expected %h", $time, s, e);
		end
	endtask
	task automatic give_verdict();
		if (failures == 0 && cmp_count > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask
	task automatic lim(input logic ok);
		if (!ok) begin
			failures++;
			give_verdict();
		end
	endtask
	function automatic logic [191:0] mapb(input logic [191:0] d, input int np);
		logic [191:0] r;
		logic [15:0]  hi, mi, lo, m;
		r = '0;
		case (i_bpc)
			3'h0: m = 16'hfc00;
			3'h2: m = 16'hffc0;
			3'h3: m = 16'hfff0;
			3'h4: m = 16'hffff;
			default: m = 16'hff00;
		endcase
		for (int k = 0; k < np; k++) begin
			hi = d[48*k+32 +: 16] & m;
			mi = d[48*k+16 +: 16] & m;
			lo = d[48*k +: 16] & m;
			case (i_format)
				sink_video_pkg::FMT_YCC422: r[48*k +: 32] = {hi, mi};
				sink_video_pkg::FMT_YONLY: r[48*k +: 16] = hi;
				default: r[48*k +: 48] = {hi, lo, mi};
			endcase
		end
		return r;
	endfunction
	task automatic send(input logic [191:0] d, input logic s, input logic e);
		exp_t x;
		logic r;
		int   np;
		np = (i_ppc == 2'h0) ? 1 : (i_ppc == 2'h1) ? 2 : 4;
		@(negedge i_clock);
		i_pix_data = d;
		i_pix_sof = s;
		i_pix_eol = e;
		i_pix_valid = 1'b1;
		r = 1'b0;
		for (int t = 0; t < 100 && !r; t++) begin
			r = o_pix_ready;
			@(posedge i_clock);
			if (!r) @(negedge i_clock);
		end
		lim(r);
		if (s) pix_cnt = 0;
		x = '0;
		x.d = mapb(d, np);
		x.u = s;
		x.l = e;
		for (int k = 0; k < np; k++) begin
			x.m[k] = 1'b1;
			x.cb[k] = (i_format == sink_video_pkg::FMT_YCC422) && ((pix_cnt + k) % 2 == 1);
		end
		q.push_back(x);
		pix_cnt = e ? 0 : pix_cnt + np;
	endtask
	task automatic burst(input int nb);
		logic [191:0] d;
		for (int j = 0; j < nb; j++) begin
			for (int w = 0; w < 6; w++) d[32*w +: 32] = $random(seed);
			send(d, j == 0, j == nb - 1);
		end
		@(negedge i_clock);
		i_pix_valid = 1'b0;
	endtask
	task automatic drain();
		for (int t = 0; t < 200 && q.size() != 0; t++) @(negedge i_clock);
		lim(q.size() == 0);
	endtask
	always @(posedge i_clock) begin
		if (i_rst_b && o_axis_tvalid && i_axis_tready) begin
			if (q.size() == 0) begin
				chk(o_axis_tvalid, 1'b0);
			end else begin
				mon_x = q.pop_front();
				chk(o_axis_tdata, mon_x.d);
				chk({o_axis_tuser, o_axis_tlast}, {mon_x.u, mon_x.l});
				chk(o_axis_chroma_cb & mon_x.m, mon_x.cb);
			end
		end
	end
	initial begin
		repeat (2) @(posedge i_clock);
		@(negedge i_clock);
		chk({o_axis_tvalid, o_pix_ready, o_vid_m, o_vid_n, o_mn_update, o_link_clk_mhz, o_aux_tick,
			o_retimer_soft_reset, o_vid_pipe_rst, o_sub_sel}, {2'h1, 65'h0, 8'hf0});
		i_rst_b = 1'b1;
		// Every format against every depth, pixel count rotating, sink stalling at random
		for (int f = 0; f < 4; f++) begin
			for (int b = 0; b < 5; b++) begin
				i_format = 2'(f);
				i_bpc = 3'(b);
				i_ppc = 2'((f + b) % 3);
				burst(3);
			end
		end
		drain();
		stall = 2'h2;
		burst(2);
		chk(o_pix_ready, 1'b0);
		i_vid_rst = 4'h1;
		@(negedge i_clock);
		i_vid_rst = 4'h0;
		q.delete();
		chk(o_axis_tvalid, 1'b0);
		stall = 2'h0;
		i_msa_m = 24'($random(seed));
		i_msa_n = 24'($random(seed));
		i_msa_valid = 1'b1;
		@(negedge i_clock);
		chk({o_mn_update, o_vid_m, o_vid_n}, {1'b1, i_msa_m, i_msa_n});
		@(negedge i_clock);
		chk(o_mn_update, 1'b0);
		i_msa_valid = 1'b0;
		for (int r = 0; r < 5; r++) begin
			i_lane_rate = 2'(r);
			i_host_addr = 32'h44c0_0000 | (32'(r) << 12) | (32'($random(seed)) & 32'h0fff);
			i_i2c_gpo = 8'($random(seed));
			i_vid_rst = {3'($random(seed)), 1'b0};
			@(negedge i_clock);
			chk(o_link_clk_mhz, lnk[r % 4]);
			chk({o_sub_sel, o_addr_hit}, r < 4 ? {4'h1 << r, 1'b1} : 5'h0);
			chk({o_retimer_soft_reset, o_vid_pipe_rst}, {i_i2c_gpo[0], i_vid_rst});
		end
		for (int t = 0; t < 2; t++) begin
			n = 0;
			do begin
				@(negedge i_clock);
				n++;
			end while (o_aux_tick !== 1'b1 && n < 40);
			lim(n < 40);
		end
		chk(n, 32'h19);
		give_verdict();
	end
endmodule
`default_nettype wire
